// ==== hdl/lds_top.v ====
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "lds_consts.vh"
// How it works
// - 30 ms low reset pin resets all
// - Noise filter setting change resets detector
// - Select button held 3 s resets channel
// - Sensitivity or frequency change resets channel
// - Channel or filter reset keeps diagnostics
// - Pin or power reset clears diagnostics
// - Green input aborts delay timing
// - Loop failure forces call output
// - Status low normally, high on failure
// - Excess change: status 50 on, 150 off
// - Backlight on press, off 15 min later
// - LED shows call, delay or failed loop
// - Tuned in 2 s, full after 30 s
// - Out-of-range loop enters fail-safe with message
// - Low type shorted, high type open
// - Fault shown while present; retune in range
// - Fail-safe gives continuous call
// - LED bursts three flashes per second, latched
// - Self-healed loop resumes, bursts continue
// - Count failures; manual reset clears count
// - Four buttons 5 s restore defaults
// - Two buttons pressed light display test
module lds_top #(
  parameter MS_CYC = `LDS_MS_CYC,
  parameter BL_MS = `LDS_BL_MS
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // APB slave
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Controller pins, active low
  input wire ext_rst_n,
  input wire [1:0] green_n,
  // Front panel buttons, high when pressed
  input wire [3:0] btn,
  // Loop front end
  input wire [1:0] occ,
  input wire [1:0] flt_lo,
  input wire [1:0] flt_hi,
  input wire [1:0] excess,
  // Controller outputs
  output wire [1:0] call_o,
  output wire [1:0] status_n_o,
  // Front panel outputs
  output wire [1:0] led_o,
  output reg backlight_o,
  output reg disp_test_o,
  output reg [2:0] restore_cnt_o,
  output reg sel_ch_o,
  output reg [5:0] diag_o,
  output wire [1:0] fault_type_low,
  output wire [1:0] fault_type_high,
  output wire [1:0] loop_fail_o,
  // Channel state to front end
  output reg [1:0] channel_select_button_rst_o,
  output wire [1:0] tuned_o,
  output wire [1:0] full_sens_o
);
  // ==========================================
  // Pin synchronisers
  wire [14:0] syn;
  lds_sync #(.W(15), .RV(15'h0007)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .d({excess, flt_hi, flt_lo, occ, btn, green_n, ext_rst_n}),
    .q(syn)
  );
  wire s_ext_n = syn[0];
  wire [1:0] s_grn_n = syn[2:1];
  wire [3:0] s_btn = syn[6:3];
  wire [1:0] s_occ = syn[8:7];
  wire [1:0] s_lo = syn[10:9];
  wire [1:0] s_hi = syn[12:11];
  wire [1:0] s_exc = syn[14:13];

  // Pressed-button count
  function [2:0] nbtn;
    input [3:0] b;
    begin
      nbtn = {2'b00, b[0]} + {2'b00, b[1]} + {2'b00, b[2]} + {2'b00, b[3]};
    end
  endfunction

  // ==========================================
  // Millisecond tick
  localparam [16:0] MS_M1 = MS_CYC[16:0] - 17'h00001;
  reg [16:0] ms_r; // Cycle count in one ms
  reg tick_r; // One-cycle pulse per ms

  // Every timer below steps on this tick
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ms_r <= 17'h00000;
      tick_r <= 1'b0;
    end else if (ms_r == MS_M1) begin
      ms_r <= 17'h00000;
      tick_r <= 1'b1;
    end else begin
      ms_r <= ms_r + 17'h00001;
      tick_r <= 1'b0;
    end
  end

  // ==========================================
  // External reset qualification
  reg [4:0] ext_cnt_r; // Ms the pin has been low
  reg det_rst_r; // Detector-wide reset pulse

  // Fires once per low period, only after 30 ms
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_cnt_r <= 5'h00;
      det_rst_r <= 1'b0;
    end else begin
      det_rst_r <= 1'b0;
      if (s_ext_n) begin
        ext_cnt_r <= 5'h00;
      end else if (tick_r && ext_cnt_r != `LDS_RST_MS) begin
        ext_cnt_r <= ext_cnt_r + 5'h01;
        det_rst_r <= (ext_cnt_r == `LDS_RST_MS - 1);
      end
    end
  end

  // ==========================================
  // Buttons: select, hold, restore, backlight
  reg [3:0] btn_q_r; // Last sampled buttons
  reg [11:0] hold_r; // Select hold time
  reg ch_btn_rst_r; // Selected-channel reset pulse
  reg [9:0] fdr_ms_r; // Ms within restore second
  reg restore_r; // Factory restore pulse
  reg [19:0] bl_r; // Backlight ms left
  reg [19:0] bl_nxt;
  wire [3:0] press = s_btn & ~btn_q_r;
  wire all4 = &s_btn;
  wire ch_rst_b = s_btn[0] && nbtn(s_btn) == 3'h1;

  // Backlight reload on any press, count down otherwise
  always @* begin
    bl_nxt = bl_r;
    if (|press) begin
      bl_nxt = BL_MS[19:0];
    end else if (tick_r && bl_r != 20'h00000) begin
      bl_nxt = bl_r - 20'h00001;
    end
  end

  // Button state machines; hold timers restart on release
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      btn_q_r <= 4'h0;
      hold_r <= 12'h000;
      ch_btn_rst_r <= 1'b0;
      fdr_ms_r <= 10'h000;
      restore_r <= 1'b0;
      restore_cnt_o <= 3'h0;
      sel_ch_o <= 1'b0;
      bl_r <= 20'h00000;
      backlight_o <= 1'b0;
      disp_test_o <= 1'b0;
    end else begin
      btn_q_r <= s_btn;
      bl_r <= bl_nxt;
      backlight_o <= |bl_nxt;
      disp_test_o <= nbtn(s_btn) >= 3'h2;
      ch_btn_rst_r <= 1'b0;
      restore_r <= 1'b0;
      // Each lone select press steps to the other channel
      if (press[0] && nbtn(s_btn) == 3'h1) begin
        sel_ch_o <= ~sel_ch_o;
      end
      // Hold with only select pressed
      if (!ch_rst_b) begin
        hold_r <= 12'h000;
      end else if (tick_r && hold_r != `LDS_CHRST_MS) begin
        hold_r <= hold_r + 12'h001;
        ch_btn_rst_r <= (hold_r == `LDS_CHRST_MS - 1);
      end
      // Restore countdown, aborted by any release
      if (!all4) begin
        restore_cnt_o <= 3'h0;
        fdr_ms_r <= 10'h000;
      end else if (press != 4'h0) begin
        restore_cnt_o <= `LDS_FDR_SEC;
        fdr_ms_r <= 10'h000;
      end else if (tick_r && restore_cnt_o != 3'h0) begin
        if (fdr_ms_r == `LDS_SEC_MS - 1) begin
          fdr_ms_r <= 10'h000;
          restore_cnt_o <= restore_cnt_o - 3'h1;
          restore_r <= (restore_cnt_o == 3'h1);
        end else begin
          fdr_ms_r <= fdr_ms_r + 10'h001;
        end
      end
    end
  end

  // ==========================================
  // APB registers
  reg nfd_r; // Noise filter disable
  reg [14:0] cfg_r; // Sensitivity and frequency
  reg [31:0] dly_r; // Delay ms per channel
  reg nfd_chg_r; // Filter setting changed
  reg [1:0] cfg_chg_r; // Channel setting changed
  wire [1:0] fault_w;
  wire [1:0] latch_w;
  wire [15:0] fcnt_w;
  wire wr_en = psel & penable & pwrite & pready;
  wire setup = psel & ~penable;
  wire [14:0] wcfg = pwdata[14:0];

  // Writes on the completing access edge
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nfd_r <= 1'b0;
      diag_o <= 6'h00;
      cfg_r <= `LDS_CFG_DEF;
      dly_r <= `LDS_DLY_DEF;
      nfd_chg_r <= 1'b0;
      cfg_chg_r <= 2'b00;
    end else begin
      nfd_chg_r <= 1'b0;
      cfg_chg_r <= 2'b00;
      if (restore_r) begin
        nfd_r <= 1'b0;
        diag_o <= 6'h00;
        cfg_r <= `LDS_CFG_DEF;
        dly_r <= `LDS_DLY_DEF;
      end else if (det_rst_r) begin
        diag_o <= 6'h00;
      end else if (wr_en) begin
        if (paddr == `LDS_A_CTRL) begin
          nfd_r <= pwdata[`LDS_CTRL_NFD];
          nfd_chg_r <= pwdata[`LDS_CTRL_NFD] ^ nfd_r;
        end else if (paddr == `LDS_A_DIAG) begin
          diag_o <= pwdata[5:0];
        end else if (paddr == `LDS_A_CFG) begin
          cfg_r <= wcfg;
          cfg_chg_r[0] <= wcfg[6:0] != cfg_r[6:0];
          cfg_chg_r[1] <= wcfg[14:8] != cfg_r[14:8];
        end else if (paddr == `LDS_A_DLY) begin
          dly_r <= pwdata;
        end
      end
    end
  end

  // Read data and answer prepared in the setup cycle
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= 1'b0;
        if (paddr == `LDS_A_CTRL) begin
          prdata <= {31'h00000000, nfd_r};
        end else if (paddr == `LDS_A_DIAG) begin
          prdata <= {26'h0000000, diag_o};
        end else if (paddr == `LDS_A_CFG) begin
          prdata <= {17'h00000, cfg_r};
        end else if (paddr == `LDS_A_DLY) begin
          prdata <= dly_r;
        end else if (paddr == `LDS_A_STAT) begin
          prdata <= {20'h00000, sel_ch_o, backlight_o, full_sens_o, tuned_o,
                     latch_w, fault_w, s_exc};
        end else if (paddr == `LDS_A_FCNT) begin
          prdata <= {16'h0000, fcnt_w};
        end else begin
          prdata <= 32'h00000000;
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // Reset sources per channel
  wire [1:0] sel_hit = sel_ch_o ? 2'b10 : 2'b01;
  // Manual resets also clear the fail alert and count
  wire [1:0] man_rst = {2{det_rst_r | restore_r}} | ({2{ch_btn_rst_r}} & sel_hit);
  wire [1:0] chrst = man_rst | {2{nfd_chg_r}} | cfg_chg_r;

  // Pulse to the front end to retune
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      channel_select_button_rst_o <= 2'b00;
    end else begin
      channel_select_button_rst_o <= chrst;
    end
  end

  // ==========================================
  // Shared flash patterns
  wire st_on;
  wire burst_on;
  lds_flash u_flash (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(tick_r),
    .st_on(st_on),
    .burst_on(burst_on)
  );

  // ==========================================
  // Channel logic
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      reg [14:0] tune_r; // Ms since reset, in range
      reg [15:0] dcnt_r; // Delay elapsed ms
      reg ddone_r; // Delay expired or aborted
      reg fprev_r; // Fault last cycle
      reg latch_r; // Burst alert latch
      reg [7:0] fcnt_r; // Failure count
      reg call_q, stat_q, led_q, lo_q, hi_q, fail_q, tuned_q, full_q;
      wire f = s_lo[c] | s_hi[c];
      wire rise = f & ~fprev_r;
      wire grn = ~s_grn_n[c];
      wire [15:0] dly = dly_r[16*c+15:16*c];
      wire tuned = tune_r >= `LDS_TUNE_MS;
      // Fault or untuned channel calls, else occupancy past delay
      wire call_w = f | ~tuned | (s_occ[c] & ddone_r);
      wire dly_act = s_occ[c] & ~ddone_r & ~grn;

      // Tuning runs only while the loop is in range
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          tune_r <= 15'h0000;
        end else if (chrst[c]) begin
          tune_r <= 15'h0000;
        end else if (tick_r && !f && tune_r != `LDS_FULL_MS) begin
          tune_r <= tune_r + 15'h0001;
        end
      end

      // Delay timing; green phase aborts it
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          dcnt_r <= 16'h0000;
          ddone_r <= 1'b0;
        end else if (chrst[c] || !s_occ[c]) begin
          dcnt_r <= 16'h0000;
          ddone_r <= 1'b0;
        end else if (grn || dcnt_r >= dly) begin
          ddone_r <= 1'b1;
        end else if (tick_r) begin
          dcnt_r <= dcnt_r + 16'h0001;
        end
      end

      // Failure edge: count and alert; a new failure beats a clear
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          fprev_r <= 1'b0;
          latch_r <= 1'b0;
          fcnt_r <= 8'h00;
        end else begin
          fprev_r <= f;
          if (rise) begin
            latch_r <= 1'b1;
          end else if (man_rst[c]) begin
            latch_r <= 1'b0;
          end
          if (man_rst[c]) begin
            fcnt_r <= {7'h00, rise};
          end else if (rise && fcnt_r != 8'hFF) begin
            fcnt_r <= fcnt_r + 8'h01;
          end
        end
      end

      // Registered outputs
      always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          call_q <= 1'b1;
          stat_q <= 1'b0;
          led_q <= 1'b0;
          lo_q <= 1'b0;
          hi_q <= 1'b0;
          fail_q <= 1'b0;
          tuned_q <= 1'b0;
          full_q <= 1'b0;
        end else begin
          call_q <= call_w;
          // Excess change pattern first, then failure level
          if (s_exc[c]) begin
            stat_q <= ~st_on;
          end else begin
            stat_q <= f;
          end
          led_q <= latch_r ? burst_on : (call_w | dly_act);
          lo_q <= s_lo[c];
          hi_q <= s_hi[c] & ~s_lo[c];
          fail_q <= f;
          tuned_q <= tuned;
          full_q <= tune_r == `LDS_FULL_MS;
        end
      end

      assign call_o[c] = call_q;
      assign status_n_o[c] = stat_q;
      assign led_o[c] = led_q;
      assign fault_type_low[c] = lo_q;
      assign fault_type_high[c] = hi_q;
      assign loop_fail_o[c] = fail_q;
      assign tuned_o[c] = tuned_q;
      assign full_sens_o[c] = full_q;
      assign fault_w[c] = f;
      assign latch_w[c] = latch_r;
      assign fcnt_w[8*c+7:8*c] = fcnt_r;
    end
  endgenerate
endmodule

// ==== hdl/lds_consts.vh ====
`ifndef LDS_CONSTS_VH
`define LDS_CONSTS_VH
// ==========================================
// Clock and tick
`define LDS_CLK_NS 8
`define LDS_MS_NS 1000000
`define LDS_MS_CYC (`LDS_MS_NS / `LDS_CLK_NS)
// ==========================================
// Intervals in milliseconds, except restore time in seconds and flash count
`define LDS_RST_MS 30
`define LDS_CHRST_MS 3000
`define LDS_BL_MS 900000
`define LDS_FDR_SEC 3'h5
`define LDS_SEC_MS 1000
`define LDS_TUNE_MS 2000
`define LDS_FULL_MS 30000
`define LDS_ST_ON_MS 50
`define LDS_ST_PER_MS 200
`define LDS_FLASH_MS 100
`define LDS_FLASHES 3
// ==========================================
// Register byte offsets
`define LDS_A_CTRL 12'h000
`define LDS_A_DIAG 12'h004
`define LDS_A_CFG 12'h008
`define LDS_A_DLY 12'h00C
`define LDS_A_STAT 12'h010
`define LDS_A_FCNT 12'h014
// ==========================================
// Fields and reset values
`define LDS_CTRL_NFD 0
`define LDS_DIAG_W 6
`define LDS_CFG_W 15
`define LDS_CFG_CH1 8
`define LDS_CFG_DEF 15'h7636
`define LDS_DLY_DEF 32'h00000000
`endif

// ==== hdl/lds_sync.v ====
`timescale 1ns/1ps
// ==========================================
// Two-flop synchroniser for pin inputs
module lds_sync #(
  parameter W = 1,
  parameter [W-1:0] RV = {W{1'b0}}
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  // First stage, read only by q
  reg [W-1:0] s1_r;

  // Both stages reset to idle pin levels
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= RV;
      q <= RV;
    end else begin
      s1_r <= d;
      q <= s1_r;
    end
  end
endmodule

// ==== hdl/lds_flash.v ====
`timescale 1ns/1ps
`include "lds_consts.vh"
// ==========================================
// Shared flash patterns on the ms tick
module lds_flash (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // One-ms tick
  input wire tick,
  // Patterns
  output reg st_on,
  output reg burst_on
);
  reg [7:0] st_r; // Status period phase
  reg [6:0] sub_r; // Within one flash slot
  reg [3:0] slot_r; // Slot in one second

  // Status 50/150 and 3-flash burst per second
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= 8'h00;
      sub_r <= 7'h00;
      slot_r <= 4'h0;
      st_on <= 1'b0;
      burst_on <= 1'b0;
    end else begin
      if (tick) begin
        st_r <= (st_r == `LDS_ST_PER_MS - 1) ? 8'h00 : st_r + 8'h01;
        if (sub_r == `LDS_FLASH_MS - 1) begin
          sub_r <= 7'h00;
          slot_r <= (slot_r == 4'h9) ? 4'h0 : slot_r + 4'h1;
        end else begin
          sub_r <= sub_r + 7'h01;
        end
      end
      st_on <= (st_r < `LDS_ST_ON_MS);
      burst_on <= (slot_r < 2 * `LDS_FLASHES) & ~slot_r[0];
    end
  end
endmodule

// ==== tb/lds_top_assertions.sv ====
`timescale 1ns/1ps
// ==========================================
// Port checker for the supervisor
module lds_chk (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Bus handshake
  input wire psel,
  input wire penable,
  input wire pready,
  // Panel
  input wire [3:0] btn,
  input wire [2:0] restore_cnt_o,
  input wire disp_test_o,
  input wire backlight_o,
  // Channel outputs
  input wire [1:0] call_o,
  input wire [1:0] status_n_o,
  input wire [1:0] loop_fail_o,
  input wire [1:0] fault_type_low,
  input wire [1:0] fault_type_high,
  input wire [1:0] channel_select_button_rst_o,
  input wire [1:0] tuned_o
);
  // One domain, so one clock and one disable
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Bus timing, no wait states
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_acc_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  // ==========================================
  // Channel 0 never sees excess, so status is plain
  fail_call_a: assert property (loop_fail_o[0] |-> call_o[0])
    else $error("fault without call");
  status_ok_a: assert property (!loop_fail_o[0] && $past(!loop_fail_o[0]) |-> !status_n_o[0])
    else $error("status off without fault");
  low_wins_a: assert property (fault_type_low[0] |-> !fault_type_high[0])
    else $error("both fault types shown");
  tune_call_a: assert property (!tuned_o[0] && $past(!tuned_o[0]) |-> call_o[0])
    else $error("no call while tuning");
  untune_a: assert property (channel_select_button_rst_o[0] |-> ##[0:2] !tuned_o[0])
    else $error("tuned kept over reset");
  // ==========================================
  // Panel; slack covers the pin synchronisers
  abort_a: assert property (btn != 4'hF |-> ##[1:4] restore_cnt_o == 3'h0)
    else $error("restore not aborted");
  test_on_a: assert property (($countones(btn) >= 2)[*5] |-> disp_test_o)
    else $error("display test missing");
  light_on_a: assert property (|(btn & ~$past(btn)) |-> ##[1:4] backlight_o)
    else $error("backlight not lit by press");
  // Main scenarios
  cover property ($rose(loop_fail_o[0]));
  cover property (restore_cnt_o == 3'h5);
  cover property (channel_select_button_rst_o == 2'h3);
endmodule
bind lds_top lds_chk i_chk (.ref_clk, .sys_rst, .psel, .penable, .pready, .btn,
  .restore_cnt_o, .disp_test_o, .backlight_o, .call_o, .status_n_o, .loop_fail_o,
  .fault_type_low, .fault_type_high, .channel_select_button_rst_o, .tuned_o);

// ==== tb/lds_ctl_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Controller side: owns the reset pin
module lds_ctl_model #(
  parameter MS_CYC = 10
) (
  // Clock
  input wire ref_clk,
  // Command from the bench
  input wire go,
  input wire [15:0] low_ms,
  // Reset pin, active low
  output reg ext_rst_n
);
  integer left = 0; // Cycles still low
  initial ext_rst_n = 1'b1;
  // Hold the pin low for exactly the commanded time
  always @(posedge ref_clk) begin
    if (go) begin
      left <= low_ms * MS_CYC;
      ext_rst_n <= 1'b0;
    end else if (left > 1) begin
      left <= left - 1;
    end else begin
      ext_rst_n <= 1'b1;
    end
  end
endmodule

// ==== tb/tb_lds_top.sv ====
`timescale 1ns/1ps
`include "lds_consts.vh"
// ==========================================
// Bench for the supervisor
module tb_lds_top;
  localparam MS = 10; // Short ms keeps the run small
  reg ref_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [11:0] paddr = 12'h000;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [31:0] pwdata = 32'h00000000;
  reg [1:0] green_n = 2'h3;
  reg [3:0] btn = 4'h0;
  reg [1:0] occ = 2'h0;
  reg [1:0] flt_lo = 2'h0;
  reg [1:0] flt_hi = 2'h0;
  reg [1:0] excess = 2'h0;
  reg go = 1'b0;
  reg [15:0] low_ms = 16'h0000;
  wire ext_rst_n;
  wire [31:0] prdata;
  wire pready, pslverr, backlight_o, disp_test_o, sel_ch_o;
  wire [1:0] call_o, status_n_o, led_o, fault_type_low, fault_type_high, loop_fail_o;
  wire [1:0] channel_select_button_rst_o, tuned_o, full_sens_o;
  wire [2:0] restore_cnt_o;
  wire [5:0] diag_o;
  reg [31:0] rd; // Last read data
  reg perr; // Last error flag
  reg [1:0] seen; // Collected reset pulses
  reg prev;
  integer n_errors = 0;
  integer comparisons = 0;
  integer k;
  integer j;
  lds_top #(.MS_CYC(MS), .BL_MS(20)) i_dut (.*);
  lds_ctl_model #(.MS_CYC(MS)) i_ctl (.*);
  always #4 ref_clk = ~ref_clk;
  // ==========================================
  // Shared helpers
  task cyc(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task chk(input [31:0] got, input [31:0] exp, input string what);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value %s exp %h seen %h", what, exp, got);
      end
    end
  endtask
  task close_out;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task give_up(input string what);
    begin
      n_errors = n_errors + 1;
      $display("timeout in %s", what);
      close_out;
    end
  endtask
  // Bus transfer, request held until pready
  task apb(input w, input [11:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      t = 0;
      do begin
        @(posedge ref_clk);
        t = t + 1;
      end while (pready !== 1'b1 && t < 50);
      if (pready !== 1'b1) give_up("apb");
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Gather reset pulses over n cycles
  task rst_seen(input integer n);
    begin
      seen = 2'h0;
      repeat (n) begin
        @(posedge ref_clk);
        seen = seen | channel_select_button_rst_o;
      end
    end
  endtask
  // Length of a status level on channel 1
  task hold_len(input logic v, output integer n);
    begin
      n = 0;
      while (status_n_o[1] === v && n < 400 * MS) begin
        cyc(1);
        n = n + 1;
      end
      if (n >= 400 * MS) give_up("status");
    end
  endtask
  // ==========================================
  // Scenarios
  task t_tune;
    begin
      chk(call_o, 2'h3, "call tuning");
      k = 0;
      while (tuned_o !== 2'h3 && k < 2100 * MS) begin
        cyc(1);
        k = k + 1;
      end
      if (k >= 2100 * MS) give_up("tune");
      chk(k >= 1998 * MS && k <= 2002 * MS, 1, "tune time");
      chk(full_sens_o, 2'h0, "not full yet");
    end
  endtask
  task t_regs;
    begin
      apb(0, `LDS_A_CFG, 0);
      chk(rd, `LDS_CFG_DEF, "cfg reset");
      apb(0, `LDS_A_DLY, 0);
      chk(rd, `LDS_DLY_DEF, "dly reset");
      apb(1, `LDS_A_DIAG, 32'h0000003F);
      apb(0, `LDS_A_DIAG, 0);
      chk(rd, 32'h0000003F, "diag");
      apb(0, 12'h020, 0);
      chk(perr, 1, "unmapped err");
      chk(rd, 0, "unmapped data");
      apb(1, `LDS_A_FCNT, 32'hFFFFFFFF);
      apb(0, `LDS_A_FCNT, 0);
      chk(rd, 0, "count idle");
    end
  endtask
  task t_delay;
    begin
      apb(1, `LDS_A_DLY, 32'h00000005);
      occ <= 2'h1;
      cyc(3 * MS);
      chk(call_o[0], 0, "delayed call");
      chk(led_o[0], 1, "led delay");
      green_n <= 2'h2;
      cyc(5);
      chk(call_o[0], 1, "green call");
      occ <= 2'h0;
      green_n <= 2'h3;
      cyc(5);
      chk(call_o[0], 0, "call gone");
      occ <= 2'h1;
      cyc(7 * MS);
      chk(call_o[0], 1, "call after delay");
      chk(led_o[0], 1, "led call");
      occ <= 2'h0;
    end
  endtask
  task t_fault;
    begin
      flt_lo <= 2'h1;
      flt_hi <= 2'h2;
      cyc(5);
      chk(call_o, 2'h3, "fail call");
      chk(status_n_o, 2'h3, "fail status");
      chk(loop_fail_o, 2'h3, "fail msg");
      chk(fault_type_low, 2'h1, "type low");
      chk(fault_type_high, 2'h2, "type high");
      flt_lo <= 2'h0;
      flt_hi <= 2'h0;
      cyc(5);
      chk(loop_fail_o, 0, "healed");
      chk(status_n_o, 0, "healed status");
      apb(0, `LDS_A_FCNT, 0);
      chk(rd, 32'h00000101, "fail count");
      j = 0;
      prev = led_o[0];
      for (k = 0; k < 1000 * MS; k = k + 1) begin
        @(posedge ref_clk);
        if (led_o[0] === 1'b1 && prev === 1'b0) j = j + 1;
        prev = led_o[0];
      end
      chk(j, 3, "flash count");
    end
  endtask
  task t_excess;
    begin
      excess <= 2'h2;
      cyc(5);
      hold_len(0, k);
      hold_len(1, k);
      hold_len(0, k);
      hold_len(1, j);
      chk(k >= 49 * MS && k <= 51 * MS, 1, "on time");
      chk(j >= 149 * MS && j <= 151 * MS, 1, "off time");
      apb(0, `LDS_A_STAT, 0);
      chk(rd, 32'h000000F2, "stat word");
      excess <= 2'h0;
    end
  endtask
  task t_chanrst;
    begin
      apb(1, `LDS_A_CFG, `LDS_CFG_DEF ^ 15'h0100);
      rst_seen(6);
      chk(seen, 2'h2, "sens reset");
      apb(1, `LDS_A_CFG, `LDS_CFG_DEF ^ 15'h0110);
      rst_seen(6);
      chk(seen, 2'h1, "freq reset");
      apb(1, `LDS_A_CTRL, 32'h00000001);
      rst_seen(6);
      chk(seen, 2'h3, "filter reset");
      chk(diag_o, 6'h3F, "diag kept");
    end
  endtask
  task t_panel;
    begin
      btn <= 4'h2;
      cyc(5);
      chk(backlight_o, 1, "light on");
      chk(disp_test_o, 0, "no test");
      btn <= 4'h6;
      cyc(5);
      chk(disp_test_o, 1, "display test");
      btn <= 4'h0;
      cyc(15 * MS);
      chk(backlight_o, 1, "light held");
      cyc(8 * MS);
      chk(backlight_o, 0, "light out");
      btn <= 4'hF;
      cyc(5);
      chk(restore_cnt_o, 5, "countdown");
      cyc(1010 * MS);
      chk(restore_cnt_o, 4, "countdown step");
      btn <= 4'h7;
      cyc(5);
      chk(restore_cnt_o, 0, "aborted");
      apb(0, `LDS_A_CFG, 0);
      chk(rd, `LDS_CFG_DEF ^ 15'h0110, "no restore");
    end
  endtask
  task t_btnrst;
    begin
      btn <= 4'h1;
      k = 0;
      seen = 2'h0;
      while (seen == 2'h0 && k < 3100 * MS) begin
        cyc(1);
        k = k + 1;
        seen = channel_select_button_rst_o;
        j = sel_ch_o;
      end
      if (k >= 3100 * MS) give_up("hold");
      chk(k >= 2999 * MS && k <= 3002 * MS, 1, "hold time");
      chk(seen, 2'h1 << j, "channel_select_button pick");
      btn <= 4'h0;
      apb(0, `LDS_A_FCNT, 0);
      chk((rd >> (8 * j)) & 32'h000000FF, 0, "count clear");
    end
  endtask
  task t_pinrst;
    begin
      low_ms <= 16'h001D;
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      rst_seen(40 * MS);
      chk(seen, 0, "short pin");
      low_ms <= 16'h001F;
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      rst_seen(40 * MS);
      chk(seen, 2'h3, "pin reset");
      chk(diag_o, 0, "diag off");
      apb(0, `LDS_A_FCNT, 0);
      chk(rd, 0, "counts gone");
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    cyc(6);
    chk(call_o, 2'h3, "reset call");
    chk(status_n_o, 0, "reset status");
    chk(diag_o, 0, "reset diag");
    sys_rst <= 1'b0;
    t_tune;
    t_regs;
    t_delay;
    t_fault;
    t_excess;
    t_chanrst;
    t_panel;
    t_btnrst;
    t_pinrst;
    close_out;
  end
endmodule
